//--- core/ulm_defs.vh
// register map, field positions, reset values and codes of the line/modem block
`ifndef ULM_DEFS_VH
`define ULM_DEFS_VH

// ==========================================================
// register indices (byte address = 4 * index)
`define ULM_IIR_IDX 3'h2
`define ULM_LCR_IDX 3'h3
`define ULM_MCR_IDX 3'h4

// ==========================================================
// reset values
`define ULM_LCR_RST 8'h00
`define ULM_MCR_RST 5'h00

// ==========================================================
// line control fields
`define ULM_LCR_LEN_LO 0
`define ULM_LCR_STOP 2
`define ULM_LCR_PEN 3
`define ULM_LCR_EVEN 4
`define ULM_LCR_STICK 5
`define ULM_LCR_BRK 6
`define ULM_LCR_DIVISOR_LATCH_SELECT 7

// ==========================================================
// handshake control fields
`define ULM_MCR_TRDY 0
`define ULM_MCR_RTS 1
`define ULM_MCR_AUX 2
`define ULM_MCR_IRQG 3
`define ULM_MCR_LOOP 4

// ==========================================================
// interrupt enable fields (from the enable register outside)
`define ULM_IER_RDA 0
`define ULM_IER_THRE 1
`define ULM_IER_LSI 2
`define ULM_IER_MSI 3

// ==========================================================
// identification codes, low nibble
`define ULM_ID_NONE 4'h1
`define ULM_ID_LSI 4'h6
`define ULM_ID_RDA 4'h4
`define ULM_ID_CTO 4'hc
`define ULM_ID_THRE 4'h2
`define ULM_ID_MSI 4'h0

// ==========================================================
// receive trigger thresholds in bytes
`define ULM_TRIG_0 5'h01
`define ULM_TRIG_1 5'h04
`define ULM_TRIG_2 5'h08
`define ULM_TRIG_3 5'h0e

// ==========================================================
// timing: character timeout in character times, 16x ticks per half bit
`define ULM_CTO_CHARS 12'h004
`define ULM_TICKS_PER_HALF 12'h008

`endif

//--- core/ulm_line_modem.v
// line format, handshake control and interrupt identification of one UART
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
`include "ulm_defs.vh"

// What this block does
// - identification bits 4 and 5 read zero
// - bits 6,7 follow FIFO enable; trigger 1/4/8/14
// - line status interrupt, code 0110, highest priority
// - data available, code 0100, second priority
// - FIFO character timeout, code 1100, four characters
// - holding empty, code 0010, cleared by read/write
// - line control bits 1:0 set data length
// - bit 2 gives 1, 1.5 or 2 stop
// - receiver checks only the first stop bit
// - bit 3 enables parity after data bits
// - bit 4 selects odd or even parity
// - bit 5 forces fixed parity bit
// - bit 6 holds transmit output at zero
// - handshake bit 0 drives terminal-ready inverted
// - handshake bit 1 drives request-send inverted
// - handshake bit 2 is internal auxiliary bit
// - handshake bit 3 gates interrupt output enable
// - bit 4 loops transmit into receiver
// - loopback feeds modem inputs from control bits
// - loopback modem interrupts from control bits
// - handshake bits 5 to 7 read zero
// - modem change flags raise code 0000
// - identification bit 0 high when idle
// - identification stays frozen during host read
module ulm_line_modem (
  input wire clk, // 10 MHz clock
  input wire rst, // synchronous reset, active high
  input wire cyc_i, // wishbone cycle
  input wire stb_i, // wishbone strobe
  input wire we_i, // wishbone write
  input wire [4:2] adr_i, // wishbone word address
  input wire [3:0] sel_i, // wishbone byte selects
  input wire [31:0] dat_i, // wishbone write data
  output reg [31:0] dat_o, // wishbone read data
  output reg ack_o, // wishbone acknowledge
  input wire [3:0] intEnable, // interrupt enable register bits 3:0
  input wire fifoEnable, // fifo mode on
  input wire [1:0] trigSelect, // receive trigger code
  input wire [4:0] rxCount, // bytes held in receive fifo
  input wire rxDataReady, // non-fifo receive buffer full
  input wire rxPush, // pulse: byte entered receive fifo
  input wire rxPop, // pulse: receive buffer read
  input wire lineErrEvent, // pulse: overrun/parity/framing/break
  input wire lineStatusRead, // pulse: line status read
  input wire holdEmptyEvent, // pulse: holding register emptied
  input wire holdWrite, // pulse: holding register written
  input wire modemStatusRead, // pulse: modem status read
  input wire baudTick, // 16x baud tick
  input wire txShiftOut, // transmit shifter serial output
  input wire [7:0] txData, // byte being framed for transmit
  input wire [7:0] rxData, // received data bits
  input wire rxParityIn, // received parity bit
  input wire rxPin, // serial receive pin
  input wire clearSendPinN, // clear-to-send pin, active low
  input wire setReadyPinN, // data-set-ready pin, active low
  input wire ringPinN, // ring pin, active low
  input wire carrierDetectPinN, // carrier-detect pin, active low
  output reg txPin, // serial transmit pin
  output reg rxShiftIn, // serial input to receive shifter
  output reg terminalReadyPinN, // terminal-ready pin, active low
  output reg requestSendPinN, // request-to-send pin, active low
  output reg irqOut, // port interrupt level
  output reg irqOe, // port interrupt output enable
  output wire divisorLatchSel, // divisor latch select
  output reg [3:0] dataBits, // data bits per character, 5..8
  output reg [2:0] stopHalfBits, // stop length in half bits
  output reg parityEnable, // parity bit present
  output reg txParityBit, // parity bit for txData
  output reg rxParityErr, // received parity mismatch
  output reg [4:0] rxTrigLevel, // trigger threshold in bytes
  output reg [7:0] modemStatus // deltas in 3:0, levels in 7:4
);

  // ==========================================================
  // registers
  reg [7:0] lcrReg;
  reg [4:0] mcrReg;
  reg [7:0] iirReg;
  reg [7:0] iirNext;
  reg threPendReg;
  reg lsiPendReg;
  reg ctoPendReg;
  reg [3:0] deltaReg;
  reg [4:0] sync1Reg;
  reg [4:0] sync2Reg;
  reg [4:0] sync3Reg;
  reg [4:0] pinReg;
  reg [3:0] modemInReg;
  reg [11:0] ctoCntReg;
  reg [11:0] charTicks;
  reg [7:0] txMasked;
  reg [7:0] rxMasked;
  reg rxExpect;
  reg rdaPend;
  reg [3:0] modemIn;

  wire loopOn = mcrReg[`ULM_MCR_LOOP];
  wire busReq = cyc_i & stb_i & ~ack_o;
  wire busWr = busReq & we_i & sel_i[0];
  wire iirAccess = cyc_i & stb_i & (adr_i == `ULM_IIR_IDX);
  wire iirRead = busReq & ~we_i & (adr_i == `ULM_IIR_IDX);
  wire [4:0] pinsIn = {carrierDetectPinN, ringPinN, setReadyPinN,
                       clearSendPinN, rxPin};

  assign divisorLatchSel = lcrReg[`ULM_LCR_DIVISOR_LATCH_SELECT];

  // ==========================================================
  // wishbone slave: one wait state, ack for every address
  always @(posedge clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      lcrReg <= `ULM_LCR_RST;
      mcrReg <= `ULM_MCR_RST;
    end else begin
      ack_o <= busReq;
      dat_o <= 32'h00000000;
      if (busReq & ~we_i) begin
        case (adr_i)
          `ULM_IIR_IDX: dat_o <= {24'h000000, iirReg};
          `ULM_LCR_IDX: dat_o <= {24'h000000, lcrReg};
          `ULM_MCR_IDX: dat_o <= {27'h0000000, mcrReg};
          default: dat_o <= 32'h00000000;
        endcase
      end
      if (busWr && adr_i == `ULM_LCR_IDX) begin
        lcrReg <= dat_i[7:0];
      end
      if (busWr && adr_i == `ULM_MCR_IDX) begin
        mcrReg <= dat_i[4:0];
      end
    end
  end

  // ==========================================================
  // pin synchronisers: a change counts once stages two and three agree
  always @(posedge clk) begin
    if (rst) begin
      sync1Reg <= 5'h1f;
      sync2Reg <= 5'h1f;
      sync3Reg <= 5'h1f;
      pinReg <= 5'h1f;
    end else begin
      sync1Reg <= pinsIn;
      sync2Reg <= sync1Reg;
      sync3Reg <= sync2Reg;
      if (sync2Reg == sync3Reg) begin
        pinReg <= sync3Reg;
      end
    end
  end

  // ==========================================================
  // modem inputs, active high: {carrier, ring, set ready, clear send}
  always @* begin
    if (loopOn) begin
      modemIn = {mcrReg[`ULM_MCR_IRQG], mcrReg[`ULM_MCR_AUX],
                 mcrReg[`ULM_MCR_TRDY], mcrReg[`ULM_MCR_RTS]};
    end else begin
      modemIn = ~pinReg[4:1];
    end
  end

  // change flags; a change in the clearing cycle is kept
  always @(posedge clk) begin
    if (rst) begin
      modemInReg <= 4'h0;
      deltaReg <= 4'h0;
      modemStatus <= 8'h00;
    end else begin
      modemInReg <= modemIn;
      deltaReg <= (modemStatusRead ? 4'h0 : deltaReg) |
                  {modemIn[3] ^ modemInReg[3],
                   ~modemIn[2] & modemInReg[2],
                   modemIn[1:0] ^ modemInReg[1:0]};
      modemStatus <= {modemIn, deltaReg};
    end
  end

  // ==========================================================
  // serial path and handshake pins, all registered
  always @(posedge clk) begin
    if (rst) begin
      txPin <= 1'b1;
      rxShiftIn <= 1'b1;
      terminalReadyPinN <= 1'b1;
      requestSendPinN <= 1'b1;
      irqOe <= 1'b0;
      irqOut <= 1'b0;
    end else begin
      if (lcrReg[`ULM_LCR_BRK]) begin
        txPin <= 1'b0;
      end else if (loopOn) begin
        txPin <= 1'b1;
      end else begin
        txPin <= txShiftOut;
      end
      rxShiftIn <= loopOn ? txShiftOut : pinReg[0];
      terminalReadyPinN <= loopOn | ~mcrReg[`ULM_MCR_TRDY];
      requestSendPinN <= loopOn | ~mcrReg[`ULM_MCR_RTS];
      irqOe <= mcrReg[`ULM_MCR_IRQG];
      irqOut <= ~iirNext[0];
    end
  end

  // ==========================================================
  // character format towards the shifters
  always @* begin
    txMasked = txData;
    rxMasked = rxData;
    case (lcrReg[1:0])
      2'b00: begin
        txMasked = {3'h0, txData[4:0]};
        rxMasked = {3'h0, rxData[4:0]};
      end
      2'b01: begin
        txMasked = {2'h0, txData[5:0]};
        rxMasked = {2'h0, rxData[5:0]};
      end
      2'b10: begin
        txMasked = {1'h0, txData[6:0]};
        rxMasked = {1'h0, rxData[6:0]};
      end
      default: begin
        txMasked = txData;
        rxMasked = rxData;
      end
    endcase
    // even sense: parity equals xor of data; odd: its complement
    if (lcrReg[`ULM_LCR_STICK]) begin
      rxExpect = ~lcrReg[`ULM_LCR_EVEN];
    end else begin
      rxExpect = lcrReg[`ULM_LCR_EVEN] ? ^rxMasked : ~^rxMasked;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      dataBits <= 4'h5;
      stopHalfBits <= 3'h2;
      parityEnable <= 1'b0;
      txParityBit <= 1'b0;
      rxParityErr <= 1'b0;
    end else begin
      dataBits <= {2'b00, lcrReg[1:0]} + 4'h5;
      if (!lcrReg[`ULM_LCR_STOP]) begin
        stopHalfBits <= 3'h2;
      end else if (lcrReg[1:0] == 2'b00) begin
        stopHalfBits <= 3'h3;
      end else begin
        stopHalfBits <= 3'h4;
      end
      parityEnable <= lcrReg[`ULM_LCR_PEN];
      if (!lcrReg[`ULM_LCR_PEN]) begin
        txParityBit <= 1'b0;
      end else if (lcrReg[`ULM_LCR_STICK]) begin
        txParityBit <= ~lcrReg[`ULM_LCR_EVEN];
      end else begin
        txParityBit <= lcrReg[`ULM_LCR_EVEN] ? ^txMasked : ~^txMasked;
      end
      // only data and parity are judged; stop checking stays at one bit
      rxParityErr <= lcrReg[`ULM_LCR_PEN] & (rxParityIn != rxExpect);
    end
  end

  // ==========================================================
  // receive trigger threshold and data-available level
  always @* begin
    case (trigSelect)
      2'b00: rxTrigLevel = `ULM_TRIG_0;
      2'b01: rxTrigLevel = `ULM_TRIG_1;
      2'b10: rxTrigLevel = `ULM_TRIG_2;
      default: rxTrigLevel = `ULM_TRIG_3;
    endcase
    // level term: clears by itself when the buffer is read down
    rdaPend = fifoEnable ? (rxCount >= rxTrigLevel) : rxDataReady;
  end

  // ==========================================================
  // character timeout: 16x ticks of four whole characters
  always @* begin
    charTicks = `ULM_TICKS_PER_HALF *
                ({7'h00, dataBits, 1'b0} + 12'h002 +
                 {10'h000, parityEnable, 1'b0} +
                 {9'h000, stopHalfBits});
  end

  always @(posedge clk) begin
    if (rst) begin
      ctoCntReg <= 12'h000;
      ctoPendReg <= 1'b0;
    end else begin
      if (rxPush | rxPop | ~fifoEnable | (rxCount == 5'h00)) begin
        ctoCntReg <= 12'h000;
      end else if (baudTick && ctoCntReg != 12'hfff) begin
        ctoCntReg <= ctoCntReg + 12'h001;
      end
      // the buffer read clears it; a new expiry in that cycle waits
      if (rxPop | ~fifoEnable) begin
        ctoPendReg <= 1'b0;
      end else if (ctoCntReg >= `ULM_CTO_CHARS * charTicks &&
                   rxCount != 5'h00) begin
        ctoPendReg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // sticky sources: set wins over clear
  always @(posedge clk) begin
    if (rst) begin
      lsiPendReg <= 1'b0;
      threPendReg <= 1'b0;
    end else begin
      lsiPendReg <= lineErrEvent | (lsiPendReg & ~lineStatusRead);
      threPendReg <= holdEmptyEvent |
                     (threPendReg & ~holdWrite &
                      ~(iirRead & iirReg[3:0] == `ULM_ID_THRE));
    end
  end

  // ==========================================================
  // prioritised identification
  always @* begin
    iirNext = {fifoEnable, fifoEnable, 2'b00, `ULM_ID_NONE};
    if (lsiPendReg & intEnable[`ULM_IER_LSI]) begin
      iirNext[3:0] = `ULM_ID_LSI;
    end else if (rdaPend & intEnable[`ULM_IER_RDA]) begin
      iirNext[3:0] = `ULM_ID_RDA;
    end else if (ctoPendReg & intEnable[`ULM_IER_RDA]) begin
      iirNext[3:0] = `ULM_ID_CTO;
    end else if (threPendReg & intEnable[`ULM_IER_THRE]) begin
      iirNext[3:0] = `ULM_ID_THRE;
    end else if ((|deltaReg) & intEnable[`ULM_IER_MSI]) begin
      iirNext[3:0] = `ULM_ID_MSI;
    end
  end

  // frozen while the host addresses it, so the code read is consistent
  always @(posedge clk) begin
    if (rst) begin
      iirReg <= {4'h0, `ULM_ID_NONE};
    end else if (!iirAccess) begin
      iirReg <= iirNext;
    end
  end

endmodule

//--- test/ulm_monitor.sv
// assertion checker on the ports of the line/modem block
`timescale 1ns/1ns
`include "ulm_defs.vh"
module ulm_monitor (
  input wire clk, // clock
  input wire rst, // sync reset
  input wire cyc_i, // bus cycle
  input wire stb_i, // bus strobe
  input wire we_i, // bus write
  input wire [4:2] adr_i, // word index
  input wire [3:0] sel_i, // byte selects
  input wire [31:0] dat_i, // write data
  input wire [31:0] dat_o, // read data
  input wire ack_o, // acknowledge
  input wire fifoEnable, // fifo mode
  input wire [1:0] trigSelect, // trigger code
  input wire [4:0] rxTrigLevel, // trigger bytes
  input wire txShiftOut, // shifter out
  input wire txPin, // serial out
  input wire rxShiftIn, // shifter in
  input wire terminalReadyPinN, // terminal ready
  input wire requestSendPinN, // send request
  input wire irqOe, // irq enable
  input wire divisorLatchSel // divisor select
);
  // ====
  // copies taken at the bus taking edge
  reg [7:0] lcrCopy_reg;
  reg [4:0] mcrCopy_reg;
  wire take = cyc_i && stb_i && !ack_o;
  wire wrTake = take && we_i && sel_i[0];
  wire rdIir = take && !we_i && adr_i == `ULM_IIR_IDX;
  always @(posedge clk) begin
    if (rst) begin
      lcrCopy_reg <= 8'h00;
      mcrCopy_reg <= 5'h00;
    end else begin
      if (wrTake && adr_i == `ULM_LCR_IDX)
        lcrCopy_reg <= dat_i[7:0];
      if (wrTake && adr_i == `ULM_MCR_IDX)
        mcrCopy_reg <= dat_i[4:0];
    end
  end
  // ====
  // properties; one cycle after a write is left alone
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_break_low: assert property ($stable(lcrCopy_reg)
    && lcrCopy_reg[6] |-> !txPin) else $error("break not low");
  a_loop_mark: assert property ($stable(mcrCopy_reg)
    && $stable(lcrCopy_reg) && mcrCopy_reg[4] && !lcrCopy_reg[6]
    |-> txPin) else $error("loop not marking");
  a_loop_feed: assert property ($stable(mcrCopy_reg)
    && mcrCopy_reg[4] |-> rxShiftIn == $past(txShiftOut))
    else $error("loop data lost");
  a_ready_inv: assert property ($stable(mcrCopy_reg) |->
    terminalReadyPinN == !(mcrCopy_reg[0] && !mcrCopy_reg[4]))
    else $error("terminal ready wrong");
  a_send_inv: assert property ($stable(mcrCopy_reg) |->
    requestSendPinN == !(mcrCopy_reg[1] && !mcrCopy_reg[4]))
    else $error("send request wrong");
  a_irq_gate: assert property ($stable(mcrCopy_reg) |->
    irqOe == mcrCopy_reg[3]) else $error("irq gate wrong");
  a_iir_upper: assert property (rdIir && $stable(fifoEnable)
    |=> ack_o && dat_o[5:4] == 2'b00
    && dat_o[7:6] == {2{$past(fifoEnable)}})
    else $error("iir upper bits wrong");
  a_mcr_read: assert property (take && !we_i
    && adr_i == `ULM_MCR_IDX |=> ack_o && dat_o == {27'h0, mcrCopy_reg})
    else $error("mcr read wrong");
  a_trig_map: assert property (rxTrigLevel ==
    (trigSelect == 2'b00 ? 5'h01 : trigSelect == 2'b01 ? 5'h04 :
    trigSelect == 2'b10 ? 5'h08 : 5'h0e)) else $error("trigger wrong");
  a_divisor_latch_select_copy: assert property (divisorLatchSel ==
    lcrCopy_reg[7]) else $error("divisor select wrong");
  c_loop: cover property (mcrCopy_reg[4] && txPin);
  c_break: cover property (lcrCopy_reg[6] && !txPin);
  c_iir: cover property (rdIir ##1 ack_o);
endmodule

bind ulm_line_modem ulm_monitor i_ulm_monitor (
  .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
  .ack_o(ack_o), .fifoEnable(fifoEnable), .trigSelect(trigSelect),
  .rxTrigLevel(rxTrigLevel), .txShiftOut(txShiftOut), .txPin(txPin),
  .rxShiftIn(rxShiftIn), .terminalReadyPinN(terminalReadyPinN),
  .requestSendPinN(requestSendPinN), .irqOe(irqOe),
  .divisorLatchSel(divisorLatchSel));

//--- test/ulm_modem_model.sv
// handshake partner: a modem answering ready and send requests
`timescale 1ns/1ns
module ulm_modem_model #(
  parameter int LAG = 4 // answer delay is LAG+1 cycles; LAG below 8
) (
  input wire clk, // clock
  input wire terminalReadyPinN, // from block
  input wire requestSendPinN, // from block
  output wire setReadyPinN, // answer to terminal ready
  output wire clearSendPinN, // answer to send request
  output wire ringPinN, // ring, pulled up
  output wire carrierDetectPinN // carrier follows set ready
);
  // ====
  // a modem answers late, never in the same cycle
  logic [7:0] readyHist_reg = 8'hff;
  logic [7:0] sendHist_reg = 8'hff;
  always @(posedge clk) begin
    readyHist_reg <= {readyHist_reg[6:0], terminalReadyPinN};
    sendHist_reg <= {sendHist_reg[6:0], requestSendPinN};
  end
  assign setReadyPinN = readyHist_reg[LAG];
  assign clearSendPinN = sendHist_reg[LAG];
  assign ringPinN = 1'b1;
  assign carrierDetectPinN = readyHist_reg[LAG];
endmodule

//--- test/tb.sv
// self-checking bench of the line/modem block
`timescale 1ns/1ns
`include "ulm_defs.vh"
module tb;
  // ====
  // signals
  logic clk, rst, cyc_i, stb_i, we_i, ack_o, fifoEnable, rxDataReady;
  logic baudTick, txShiftOut, rxParityIn, rxPin, txPin, rxShiftIn;
  logic terminalReadyPinN, requestSendPinN, irqOut, irqOe;
  logic divisorLatchSel, parityEnable, txParityBit, rxParityErr;
  logic [4:2] adr_i;
  logic [3:0] sel_i, intEnable, dataBits;
  logic [31:0] dat_i, dat_o;
  logic [1:0] trigSelect;
  logic [4:0] rxCount, rxTrigLevel;
  logic [7:0] txData, rxData, modemStatus;
  logic [2:0] stopHalfBits;
  logic [6:0] pv;
  wire clearSendPinN, setReadyPinN, ringPinN, carrierDetectPinN;
  wire rxPush, rxPop, lineErrEvent, lineStatusRead;
  wire holdEmptyEvent, holdWrite, modemStatusRead;
  int n_mismatch = 0;
  int n_checks = 0;
  assign {modemStatusRead, holdWrite, holdEmptyEvent, lineStatusRead,
    lineErrEvent, rxPop, rxPush} = pv;
  ulm_line_modem i_ulm_line_modem (
    .clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .intEnable(intEnable), .fifoEnable(fifoEnable),
    .trigSelect(trigSelect), .rxCount(rxCount), .rxDataReady(rxDataReady),
    .rxPush(rxPush), .rxPop(rxPop), .lineErrEvent(lineErrEvent),
    .lineStatusRead(lineStatusRead), .holdEmptyEvent(holdEmptyEvent),
    .holdWrite(holdWrite), .modemStatusRead(modemStatusRead),
    .baudTick(baudTick), .txShiftOut(txShiftOut), .txData(txData),
    .rxData(rxData), .rxParityIn(rxParityIn), .rxPin(rxPin),
    .clearSendPinN(clearSendPinN), .setReadyPinN(setReadyPinN),
    .ringPinN(ringPinN), .carrierDetectPinN(carrierDetectPinN),
    .txPin(txPin), .rxShiftIn(rxShiftIn),
    .terminalReadyPinN(terminalReadyPinN),
    .requestSendPinN(requestSendPinN), .irqOut(irqOut), .irqOe(irqOe),
    .divisorLatchSel(divisorLatchSel), .dataBits(dataBits),
    .stopHalfBits(stopHalfBits), .parityEnable(parityEnable),
    .txParityBit(txParityBit), .rxParityErr(rxParityErr),
    .rxTrigLevel(rxTrigLevel), .modemStatus(modemStatus));
  ulm_modem_model #(.LAG(6)) i_ulm_modem_model (
    .clk(clk), .terminalReadyPinN(terminalReadyPinN),
    .requestSendPinN(requestSendPinN), .setReadyPinN(setReadyPinN),
    .clearSendPinN(clearSendPinN), .ringPinN(ringPinN),
    .carrierDetectPinN(carrierDetectPinN));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ====
  // helpers
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    pv[b] <= 1'b1;
    @(posedge clk);
    pv[b] <= 1'b0;
  endtask
  task automatic wb(input [2:0] a, input w, input [7:0] d,
    output [7:0] q);
    int k;
    @(posedge clk);
    {cyc_i, stb_i, we_i, adr_i} <= {2'b11, w, a};
    dat_i <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    chk(ack_o, 1, "no ack");
    if (ack_o !== 1'b1)
      results;
    q = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task automatic wr(input [2:0] a, input [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask
  task automatic rd(input [2:0] a, input [7:0] e, input string m);
    logic [7:0] q;
    wb(a, 1'b0, 8'h00, q);
    chk(q, e, m);
  endtask
  // ====
  // scenarios
  task automatic t_reset;
    rd(`ULM_LCR_IDX, 8'h00, "lcr reset");
    rd(3'h7, 8'h00, "unmapped");
    wr(`ULM_IIR_IDX, 8'hff);
    rd(`ULM_IIR_IDX, 8'h01, "iir idle");
  endtask
  task automatic t_format;
    for (int i = 0; i < 8; i++) begin
      wr(`ULM_LCR_IDX, 8'(i));
      waitc(2);
      chk(dataBits, 5 + i % 4, "length");
      chk(stopHalfBits, i < 4 ? 2 : (i == 4 ? 3 : 4), "stop");
    end
    wr(`ULM_LCR_IDX, 8'h80);
    rd(`ULM_LCR_IDX, 8'h80, "lcr read");
  endtask
  task automatic t_parity;
    logic [7:0] m [4] = '{8'h0b, 8'h1b, 8'h2b, 8'h3b};
    logic e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    {txData, rxData} <= 16'h0707;
    for (int i = 0; i < 4; i++) begin
      wr(`ULM_LCR_IDX, m[i]);
      rxParityIn <= e[i];
      waitc(3);
      chk(parityEnable, 1, "parity on");
      chk(txParityBit, e[i], "tx parity");
      chk(rxParityErr, 0, "rx good");
      rxParityIn <= ~e[i];
      waitc(3);
      chk(rxParityErr, 1, "rx bad");
    end
    wr(`ULM_LCR_IDX, 8'h73);
    waitc(3);
    chk(parityEnable, 0, "parity off");
    chk(rxParityErr, 0, "no check");
    chk(txPin, 0, "break");
    wr(`ULM_LCR_IDX, 8'h00);
  endtask
  task automatic t_irq;
    intEnable <= 4'hf;
    pulse(4);
    rd(`ULM_IIR_IDX, 8'h02, "thre");
    rd(`ULM_IIR_IDX, 8'h01, "thre read");
    pulse(4);
    pulse(5);
    rd(`ULM_IIR_IDX, 8'h01, "thre write");
    rxDataReady <= 1'b1;
    pulse(2);
    rd(`ULM_IIR_IDX, 8'h06, "line status");
    chk(irqOut, 1, "irq set");
    pulse(3);
    rd(`ULM_IIR_IDX, 8'h04, "data avail");
    {rxDataReady, intEnable} <= 5'h00;
    pulse(2);
    rd(`ULM_IIR_IDX, 8'h01, "masked");
    intEnable <= 4'hf;
    rd(`ULM_IIR_IDX, 8'h06, "unmasked");
    pulse(3);
    waitc(2);
    chk(irqOut, 0, "irq idle");
  endtask
  task automatic t_modem;
    intEnable <= 4'h8;
    wr(`ULM_MCR_IDX, 8'h03);
    waitc(2);
    chk({terminalReadyPinN, requestSendPinN}, 0, "pins on");
    waitc(20);
    chk(modemStatus[7:4], 4'hb, "modem in");
    rd(`ULM_IIR_IDX, 8'h00, "modem irq");
    pulse(6);
    rd(`ULM_IIR_IDX, 8'h01, "modem read");
    txShiftOut <= 1'b0;
    wr(`ULM_MCR_IDX, 8'h1c);
    waitc(10);
    chk({terminalReadyPinN, requestSendPinN}, 3, "loop pins");
    chk({txPin, rxShiftIn}, 2, "loop data");
    chk(modemStatus[7:4], 4'hc, "loop feed");
    rd(`ULM_IIR_IDX, 8'h00, "loop irq");
    chk(irqOe, 1, "gate on");
    wr(`ULM_MCR_IDX, 8'hff);
    rd(`ULM_MCR_IDX, 8'h1f, "mcr bits");
    wr(`ULM_MCR_IDX, 8'h00);
    waitc(2);
    chk(irqOe, 0, "gate off");
    pulse(6);
    txShiftOut <= 1'b1;
  endtask
  task automatic t_fifo;
    logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
    {fifoEnable, intEnable} <= 5'h11;
    for (int i = 0; i < 4; i++) begin
      trigSelect <= 2'(i);
      waitc(2);
      chk(rxTrigLevel, lv[i], "trigger");
    end
    rxCount <= 5'h0e;
    rd(`ULM_IIR_IDX, 8'hc4, "fifo data");
    rxCount <= 5'h0d;
    rd(`ULM_IIR_IDX, 8'hc1, "below trigger");
    {rxCount, baudTick} <= 6'h03;
    // four 7-bit characters of 16 ticks: 448 ticks before the flag
    waitc(440);
    chk(irqOut, 0, "early timeout");
    for (int k = 0; k < 20 && irqOut !== 1'b1; k++)
      @(posedge clk);
    chk(irqOut, 1, "late timeout");
    if (irqOut !== 1'b1)
      results;
    rd(`ULM_IIR_IDX, 8'hcc, "timeout");
    {rxCount, baudTick} <= 6'h00;
    pulse(1);
    rd(`ULM_IIR_IDX, 8'hc1, "timeout clear");
    fifoEnable <= 1'b0;
  endtask
  // ====
  // main sequence
  initial begin
    {cyc_i, stb_i, we_i, pv, baudTick, fifoEnable, rxDataReady} = '0;
    {adr_i, dat_i, intEnable, trigSelect, rxCount} = '0;
    {txData, rxData, rxParityIn} = '0;
    {sel_i, txShiftOut, rxPin, rst} = 7'h7f;
    waitc(8);
    rst <= 1'b0;
    t_reset;
    t_format;
    t_parity;
    t_irq;
    t_modem;
    t_fifo;
    results;
  end
endmodule
